/* File: verilog/pswc_pkg.sv */
// Package for the power state and wake control block.
// Holds states, interface choices, idle parameters and timing counts.
package pswc_pkg;

   // Operating states across both modes.
   typedef enum logic [2:0] {
      PSWC_POWER_UP,
      PSWC_HIBERNATE,
      PSWC_SLEEP,
      PSWC_TAG_DETECT,
      PSWC_READY,
      PSWC_READER
   } pswc_state_t;

   typedef enum logic [1:0] {
      PSWC_IF_NONE,
      PSWC_IF_UART,
      PSWC_IF_SPI
   } pswc_iface_t;

   // Host commands that change state, already decoded by the framer.
   typedef enum logic [2:0] {
      PSWC_CMD_NONE,
      PSWC_CMD_PROTOCOL,
      PSWC_CMD_HIBERNATE,
      PSWC_CMD_SLEEP,
      PSWC_CMD_TAG_DETECT,
      PSWC_CMD_FIELD_OFF
   } pswc_cmd_t;

   // Wake source enables carried by the idle command.
   typedef struct packed {
      logic tag_det;
      logic ss_pin;
      logic irq_pin;
      logic timer;
   } pswc_wake_t;

   typedef struct packed {
      pswc_cmd_t  cmd;
      pswc_wake_t wake_en;
   } pswc_host_cmd_t;

   // Bit positions of the wake event report.
   localparam int PSWC_EV_TIMER = 0;
   localparam int PSWC_EV_IRQ = 1;
   localparam int PSWC_EV_SS = 2;
   localparam int PSWC_EV_TAG = 3;

   localparam pswc_wake_t PSWC_WAKE_RESET = 4'h0;

   // Minimum wake pulse width and the slow clock that measures it.
   localparam int PSWC_WAKE_MIN_NS = 10000;
   localparam int PSWC_SLOW_PERIOD_NS = 1000;
   localparam int PSWC_WAKE_MIN_SLOW =
      (PSWC_WAKE_MIN_NS + PSWC_SLOW_PERIOD_NS - 1) / PSWC_SLOW_PERIOD_NS;
   localparam int PSWC_CNT_W = 8;

   // Fast oscillator startup delay, in microseconds and system cycles.
   localparam int PSWC_CLK_NS = 10;
   localparam int PSWC_OSC_SU_US = 10000;
   localparam int PSWC_OSC_SU_CYC = PSWC_OSC_SU_US * 1000 / PSWC_CLK_NS;

endpackage

/* File: verilog/pswc_pulse_meter.sv */
// Measures the low width of the wake input in slow oscillator cycles.
// Assumes wake_n_s and slow_tick are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pswc_pulse_meter #(
   parameter int MIN_TICKS = 10
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst_sync_b, // Synchronised reset, active low.
   input wire logic arm, // Measurement allowed.
   input wire logic wake_n_s, // Synchronised wake input.
   input wire logic slow_tick, // One pulse per slow cycle.
   output logic pulse_ok // Valid pulse seen, one cycle.
);
   import pswc_pkg::*;

   logic [PSWC_CNT_W-1:0] width_q;
   logic wake_n_q;

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wake_n_q <= 1'b1;
      end else begin
         wake_n_q <= wake_n_s;
      end
   end

   // Counting only on slow ticks rejects glitches shorter than the minimum.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         width_q <= '0;
      end else if (!arm || wake_n_s) begin
         width_q <= '0;
      end else if (slow_tick && width_q != PSWC_CNT_W'(MIN_TICKS)) begin
         width_q <= width_q + PSWC_CNT_W'(1); // [R16]
      end
   end

   // A pulse counts on its rising edge once it lasted long enough.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pulse_ok <= 1'b0;
      end else begin
         pulse_ok <= arm && wake_n_s && !wake_n_q &&
            width_q == PSWC_CNT_W'(MIN_TICKS); // [R2] [R3] [R16]
      end
   end
endmodule
`default_nettype wire

/* File: verilog/pswc_top.sv */
// Power state and wake control of a contactless reader transceiver.
// Assumes a command framer decodes host commands and a slow oscillator
// tick arrives on sys_clk; pins pass two synchronising flip-flops.
//
// How it works
// R1 - Low-power wait mode has four states; active two.
// R2 - After reset, power-up waits for long wake pulse.
// R3 - Hibernate wakes only on long wake pulse.
// R4 - Sleep wakes on enabled timer, wake, select.
// R5 - Tag detect adds tag event as wake source.
// R6 - Ready keeps field off, waits host command.
// R7 - Reader talks to tag and host.
// R8 - Low-power states entered only by host command.
// R9 - Low-power states ignore host communication.
// R10 - Idle command parameters set wake sources.
// R11 - Wake pulse selects interface, ready after startup.
// R12 - Serial select input is active low.
// R13 - Both selects low gives UART; a high gives SPI. Code gives SPI only with b low, and no interface when b is high.
// R14 - Selection latched on wake edge after power-up/hibernate.
// R15 - Wake pulse is not a UART start bit.
// R16 - Wake width counted in slow cycles; short rejected.
// R17 - Sleep or tag wake returns to ready, same interface.
`timescale 1ns/1ps
`default_nettype none
module pswc_top #(
   parameter int OSC_SU_CYC = pswc_pkg::PSWC_OSC_SU_CYC,
   parameter int WAKE_MIN_SLOW = pswc_pkg::PSWC_WAKE_MIN_SLOW
) (
   input wire logic sys_clk, // 100 MHz system clock.
   input wire logic rst_b, // Power-on reset, active low.
   input wire logic wake_irq_n, // Shared receive and wake pin.
   input wire logic serial_select_n, // Serial slave select pin.
   input wire logic interface_select_a, // Interface strap a.
   input wire logic interface_select_b, // Interface strap b.
   input wire logic slow_tick, // Slow oscillator tick, on sys_clk.
   input wire logic timer_expired, // Wake timer pulse, on sys_clk.
   input wire logic tag_detected, // Tag detector pulse, on sys_clk.
   input wire pswc_pkg::pswc_host_cmd_t host_cmd, // Decoded host command.
   output pswc_pkg::pswc_state_t state, // Current state.
   output logic active_mode, // High in ready or reader.
   output pswc_pkg::pswc_iface_t iface_sel, // Selected interface.
   output logic host_comm_en, // Host interface may talk.
   output logic uart_rx_gate, // Receiver may decode start bits.
   output logic rf_field_on, // Field enable.
   output logic slow_osc_en, // Slow oscillator runs.
   output logic fast_osc_en, // Fast oscillator runs.
   output logic [3:0] wake_event // Last wake cause, registered.
);
   import pswc_pkg::*;

   localparam int SU_W = $clog2(OSC_SU_CYC + 1);

   logic [1:0] rst_pipe_q;
   logic rst_sync_b;
   logic [1:0] wake_pipe_q, ss_pipe_q, sa_pipe_q, sb_pipe_q;
   logic wake_n_s, ss_n_s, sel_a_s, sel_b_s;
   logic wake_n_q;
   pswc_state_t state_q;
   pswc_iface_t iface_q;
   pswc_wake_t wake_en_q;
   logic [SU_W-1:0] su_cnt_q;
   logic starting_q;
   logic pulse_ok;
   logic arm;
   logic in_wait;
   logic rx_mask_q;
   logic [3:0] wake_event_q;
   logic [3:0] src_hit;
   logic waking;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_q[1];

   // Pin synchronisers; the reset values match idle pin levels.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wake_pipe_q <= 2'h3;
         ss_pipe_q <= 2'h3;
         sa_pipe_q <= 2'h0;
         sb_pipe_q <= 2'h0;
      end else begin
         wake_pipe_q <= {wake_pipe_q[0], wake_irq_n};
         ss_pipe_q <= {ss_pipe_q[0], serial_select_n};
         sa_pipe_q <= {sa_pipe_q[0], interface_select_a};
         sb_pipe_q <= {sb_pipe_q[0], interface_select_b};
      end
   end
   assign wake_n_s = wake_pipe_q[1];
   assign ss_n_s = ss_pipe_q[1];
   assign sel_a_s = sa_pipe_q[1];
   assign sel_b_s = sb_pipe_q[1];

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wake_n_q <= 1'b1;
      end else begin
         wake_n_q <= wake_n_s;
      end
   end

   assign in_wait = state_q == PSWC_POWER_UP || state_q == PSWC_HIBERNATE ||
      state_q == PSWC_SLEEP || state_q == PSWC_TAG_DETECT; // [R1]
   assign arm = in_wait && !starting_q;

   pswc_pulse_meter #(
      .MIN_TICKS(WAKE_MIN_SLOW)
   ) u_meter (
      .sys_clk(sys_clk),
      .rst_sync_b(rst_sync_b),
      .arm(arm),
      .wake_n_s(wake_n_s),
      .slow_tick(slow_tick),
      .pulse_ok(pulse_ok)
   );

   // Sources from sleep and tag detect, each gated by its enable; power-up and hibernate take the wake pulse ungated.
   always_comb begin
      src_hit = 4'h0;
      if (state_q == PSWC_SLEEP || state_q == PSWC_TAG_DETECT) begin
         src_hit[PSWC_EV_TIMER] = wake_en_q.timer && timer_expired; // [R4]
         src_hit[PSWC_EV_IRQ] = wake_en_q.irq_pin && pulse_ok;
         src_hit[PSWC_EV_SS] = wake_en_q.ss_pin && !ss_n_s; // [R12]
      end
      if (state_q == PSWC_TAG_DETECT) begin
         src_hit[PSWC_EV_TAG] = wake_en_q.tag_det && tag_detected; // [R5]
      end
      if (state_q == PSWC_POWER_UP || state_q == PSWC_HIBERNATE) begin
         src_hit[PSWC_EV_IRQ] = pulse_ok; // [R2] [R3]
      end
   end
   assign waking = arm && src_hit != 4'h0;

   // Commands move the machine only in active mode; in wait states they drop.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_q <= PSWC_POWER_UP; // [R2]
      end else begin
         unique case (state_q)
            PSWC_POWER_UP, PSWC_HIBERNATE, PSWC_SLEEP, PSWC_TAG_DETECT: begin
               if (starting_q && su_cnt_q == '0) begin
                  state_q <= PSWC_READY; // [R11] [R17]
               end
            end
            PSWC_READY, PSWC_READER: begin
               unique case (host_cmd.cmd)
                  PSWC_CMD_HIBERNATE: state_q <= PSWC_HIBERNATE; // [R8]
                  PSWC_CMD_SLEEP: state_q <= PSWC_SLEEP; // [R8]
                  PSWC_CMD_TAG_DETECT: state_q <= PSWC_TAG_DETECT; // [R8]
                  PSWC_CMD_PROTOCOL: state_q <= PSWC_READER; // [R6]
                  PSWC_CMD_FIELD_OFF: state_q <= PSWC_READY;
                  default: state_q <= state_q;
               endcase
            end
            default: state_q <= PSWC_POWER_UP;
         endcase
      end
   end

   // Startup delay of the fast oscillator after a valid wake.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         starting_q <= 1'b0;
         su_cnt_q <= '0;
      end else if (waking) begin
         starting_q <= 1'b1;
         su_cnt_q <= SU_W'(OSC_SU_CYC - 1); // [R11]
      end else if (starting_q) begin
         if (su_cnt_q == '0) begin
            starting_q <= 1'b0;
         end else begin
            su_cnt_q <= su_cnt_q - SU_W'(1);
         end
      end
   end

   // Straps are sampled at the falling wake edge that begins the pulse.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         iface_q <= PSWC_IF_NONE;
      end else if ((state_q == PSWC_POWER_UP || state_q == PSWC_HIBERNATE)
            && !starting_q && wake_n_q && !wake_n_s) begin // [R14]
         if (!sel_a_s && !sel_b_s) begin
            iface_q <= PSWC_IF_UART; // [R13]
         end else if (sel_a_s && !sel_b_s) begin
            iface_q <= PSWC_IF_SPI; // [R13]
         end else begin
            iface_q <= PSWC_IF_NONE;
         end
      end
   end

   // Wake enables come with the idle command.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wake_en_q <= PSWC_WAKE_RESET;
      end else if ((state_q == PSWC_READY || state_q == PSWC_READER) &&
            (host_cmd.cmd == PSWC_CMD_SLEEP ||
             host_cmd.cmd == PSWC_CMD_TAG_DETECT)) begin
         wake_en_q <= host_cmd.wake_en; // [R10]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wake_event_q <= 4'h0;
      end else if (waking) begin
         wake_event_q <= src_hit;
      end
   end

   // The receiver stays masked until the wake pin returns high in ready,
   // so the tail of the wake pulse never looks like a start bit.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rx_mask_q <= 1'b1;
      end else if (in_wait) begin
         rx_mask_q <= 1'b1; // [R15]
      end else if (wake_n_s) begin
         rx_mask_q <= 1'b0;
      end
   end

   assign state = state_q;
   assign active_mode = !in_wait;
   assign iface_sel = iface_q;
   assign host_comm_en = !in_wait; // [R9] [R7]
   assign uart_rx_gate = !in_wait && !rx_mask_q &&
      iface_q == PSWC_IF_UART; // [R15]
   assign rf_field_on = state_q == PSWC_READER; // [R6] [R7]
   assign slow_osc_en = state_q != PSWC_HIBERNATE; // [R4] [R5]
   assign fast_osc_en = !in_wait || starting_q;
   assign wake_event = wake_event_q;
endmodule
`default_nettype wire

/* File: testbench/pswc_top_sva.sv */
// Port checker for the power state and wake control block.
// Assumes it is bound into pswc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pswc_top_sva import pswc_pkg::*; #(
   parameter int OSC_SU_CYC = 20,
   parameter int WAKE_MIN_SLOW = 3
) (
   input wire logic sys_clk, // Clock.
   input wire logic rst_b, // Reset, active low.
   input wire pswc_pkg::pswc_host_cmd_t host_cmd, // Host command.
   input wire pswc_pkg::pswc_state_t state, // State.
   input wire logic active_mode, // Active mode.
   input wire pswc_pkg::pswc_iface_t iface_sel, // Interface.
   input wire logic host_comm_en, // Host talk.
   input wire logic uart_rx_gate, // Receiver gate.
   input wire logic rf_field_on, // Field.
   input wire logic slow_osc_en, // Slow oscillator.
   input wire logic fast_osc_en, // Fast oscillator.
   input wire logic [3:0] wake_event // Wake cause.
);
   logic [31:0] su_q;
   // Startup length is counted here because it is far beyond a delay.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) su_q <= 32'h0;
      else su_q <= (fast_osc_en && !active_mode) ? su_q + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_wait_quiet: assert property (!active_mode |->
      !host_comm_en && !uart_rx_gate) else $error("wait state talks");
   a_slow_osc: assert property (slow_osc_en ==
      (state != PSWC_HIBERNATE)) else $error("slow oscillator wrong");
   a_field_reader: assert property (rf_field_on ==
      (state == PSWC_READER)) else $error("field wrong");
   a_cmd_enter: assert property (active_mode && host_cmd.cmd inside
      {PSWC_CMD_HIBERNATE, PSWC_CMD_SLEEP, PSWC_CMD_TAG_DETECT} |=>
      state == pswc_state_t'($past(host_cmd.cmd) - 3'h1))
      else $error("idle command not taken");
   a_enter_only: assert property ($fell(active_mode) |->
      $past(host_cmd.cmd) inside {PSWC_CMD_HIBERNATE, PSWC_CMD_SLEEP,
      PSWC_CMD_TAG_DETECT}) else $error("wait entered without command");
   a_wait_ignore: assert property (!active_mode &&
      host_cmd.cmd == PSWC_CMD_PROTOCOL |=> state != PSWC_READER)
      else $error("command taken in wait state");
   a_wake_cause: assert property ($rose(active_mode) &&
      $past(state) inside {PSWC_SLEEP, PSWC_TAG_DETECT} |->
      wake_event != 4'h0 && $stable(iface_sel)) else $error("bad wake");
   a_iface_hold: assert property (active_mode && $past(active_mode) |->
      $stable(iface_sel)) else $error("interface changed while active");
   a_startup_time: assert property ($rose(active_mode) &&
      $past(state) inside {PSWC_POWER_UP, PSWC_HIBERNATE} |->
      su_q == 32'(OSC_SU_CYC)) else $error("startup length wrong");
   a_rx_gate: assert property (uart_rx_gate |->
      iface_sel == PSWC_IF_UART && active_mode) else $error("rx gate open");
endmodule
bind pswc_top pswc_top_sva #(.OSC_SU_CYC(OSC_SU_CYC),
   .WAKE_MIN_SLOW(WAKE_MIN_SLOW)) u_sva (.sys_clk(sys_clk), .rst_b(rst_b),
   .host_cmd(host_cmd), .state(state), .active_mode(active_mode),
   .iface_sel(iface_sel), .host_comm_en(host_comm_en),
   .uart_rx_gate(uart_rx_gate), .rf_field_on(rf_field_on),
   .slow_osc_en(slow_osc_en), .fast_osc_en(fast_osc_en),
   .wake_event(wake_event));
`default_nettype wire

/* File: testbench/pswc_host_model.sv */
// Host model: drives the wake pin, select pin and decoded commands.
// Assumes the bench calls its tasks; signals change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module pswc_host_model (
   input wire logic sys_clk, // System clock.
   output logic wake_irq_n, // Wake pin, pulled up when idle.
   output logic serial_select_n, // Select pin, idle high.
   output pswc_pkg::pswc_host_cmd_t host_cmd // Decoded command.
);
   import pswc_pkg::*;
   initial begin
      wake_irq_n = 1'b1;
      serial_select_n = 1'b1;
      host_cmd = '0;
   end
   // Idle states are only ever reached through these commands.
   task automatic send(input pswc_cmd_t c, input pswc_wake_t en);
      @(negedge sys_clk);
      host_cmd = '{c, en};
      @(negedge sys_clk);
      host_cmd = '0;
   endtask
   // Drives one pin low for n cycles; select is active low.
   task automatic low(input bit sel, input int n);
      @(negedge sys_clk);
      if (sel) serial_select_n = 1'b0;
      else wake_irq_n = 1'b0;
      repeat (n) @(negedge sys_clk);
      serial_select_n = 1'b1;
      wake_irq_n = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: testbench/pswc_top_tb_top.sv */
// Bench for the power state and wake control block, with a host model.
// Assumes short startup and pulse counts; slow tick every 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module pswc_top_tb_top;
   import pswc_pkg::*;
   localparam int SU = 20;
   localparam int MW = 3;
   logic sys_clk, rst_b, sel_a, sel_b, slow_tick, timer_exp, tag_det;
   logic wake_irq_n, serial_select_n, active_mode, host_comm_en;
   logic uart_rx_gate, rf_field_on, slow_osc_en, fast_osc_en;
   logic [3:0] wake_event;
   pswc_host_cmd_t host_cmd;
   pswc_state_t state;
   pswc_iface_t iface_sel;
   int errors = 0, comparisons = 0, cyc = 0, exp_state, exp_iface;
   pswc_top #(.OSC_SU_CYC(SU), .WAKE_MIN_SLOW(MW)) u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .wake_irq_n(wake_irq_n),
      .serial_select_n(serial_select_n), .interface_select_a(sel_a),
      .interface_select_b(sel_b), .slow_tick(slow_tick),
      .timer_expired(timer_exp), .tag_detected(tag_det),
      .host_cmd(host_cmd), .state(state), .active_mode(active_mode),
      .iface_sel(iface_sel), .host_comm_en(host_comm_en),
      .uart_rx_gate(uart_rx_gate), .rf_field_on(rf_field_on),
      .slow_osc_en(slow_osc_en), .fast_osc_en(fast_osc_en),
      .wake_event(wake_event));
   pswc_host_model u_host (.sys_clk(sys_clk), .wake_irq_n(wake_irq_n),
      .serial_select_n(serial_select_n), .host_cmd(host_cmd));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) slow_tick <= (cyc % 4 == 0);
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         end_sim();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp;
      check(8'(state), 8'(exp_state));
      check(8'(iface_sel), 8'(exp_iface));
      check(8'(rf_field_on), 8'(exp_state == 5));
      check(8'({active_mode, host_comm_en, fast_osc_en}),
         exp_state >= 4 ? 8'h7 : 8'h0);
   endtask
   task automatic wait_active;
      for (int i = 0; i < SU + 60 && active_mode !== 1'b1; i++)
         @(negedge sys_clk);
   endtask
   // Fires one source: 0 timer, 1 wake pin, 2 select pin, 3 tag event.
   task automatic fire(input int src);
      @(negedge sys_clk);
      if (src == 1) u_host.low(1'b0, 4 * MW + 8);
      else if (src == 2) u_host.low(1'b1, 6);
      else begin
         timer_exp = (src == 0);
         tag_det = (src == 3);
         @(negedge sys_clk);
         timer_exp = 1'b0;
         tag_det = 1'b0;
      end
   endtask
   initial begin
      int o;
      {rst_b, sel_a, sel_b, timer_exp, tag_det} = 5'h00;
      void'($urandom(32'h3171));
      exp_state = 0;
      exp_iface = 0;
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge sys_clk);
      cmp();
      check(8'({slow_osc_en, fast_osc_en, wake_event}), 8'h20);
      sel_a = 1'b1; // Straps ask for SPI on this short pulse.
      u_host.low(1'b0, 5);
      exp_iface = 2;
      repeat (SU + 20) @(negedge sys_clk);
      cmp();
      sel_a = 1'b0;
      u_host.low(1'b0, 4 * MW + 8);
      exp_iface = 1;
      wait_active();
      exp_state = 4;
      cmp();
      // The receiver mask clears one edge after ready is reached.
      @(negedge sys_clk);
      check(8'(uart_rx_gate), 8'h1);
      u_host.send(PSWC_CMD_PROTOCOL, PSWC_WAKE_RESET);
      exp_state = 5;
      cmp();
      u_host.send(PSWC_CMD_FIELD_OFF, PSWC_WAKE_RESET);
      exp_state = 4;
      cmp();
      for (int s = 0; s < 7; s++) begin
         o = s < 3 ? s : s - 3;
         u_host.send(s < 3 ? PSWC_CMD_SLEEP : PSWC_CMD_TAG_DETECT,
            pswc_wake_t'(4'h1 << o));
         exp_state = s < 3 ? 2 : 3;
         cmp();
         u_host.send(PSWC_CMD_PROTOCOL, PSWC_WAKE_RESET);
         fire((o + 1 + $urandom_range(2, 0)) % 4);
         repeat (4) @(negedge sys_clk);
         cmp();
         fire(o);
         wait_active();
         exp_state = 4;
         cmp();
         check(8'(wake_event), 8'(1 << o));
      end
      u_host.send(PSWC_CMD_HIBERNATE, 4'hF);
      exp_state = 1;
      cmp();
      check(8'(slow_osc_en), 8'h0);
      fire(0);
      fire(2);
      fire(3);
      cmp();
      sel_a = 1'b1;
      u_host.low(1'b0, 4 * MW + 8);
      exp_iface = 2;
      wait_active();
      exp_state = 4;
      cmp();
      check(8'(uart_rx_gate), 8'h0);
      end_sim();
   end
endmodule
`default_nettype wire
